// ### hw/smmd_decoder.sv
// Purpose: steers core bus accesses to flash, sram or peripheral space
// Assumes: all inputs come from logic on clock_i
// Notes: flash is read only on this path; writes there are acknowledged
// Behaviour
// - one bus, byte, half and word sizes
// - linear byte address space, one region each for flash and sram, two for the peripheral port
// - little endian byte lanes
// - flash aliased at zero after reset
// - remap bit cleared puts sram at zero
// - flash is 32k halfwords, 256 byte pages
// - 62k user flash, top 2k boot page
// - word fetch from flash takes two reads
// - one flash halfword read per byte or half access
// - sram 2k x 32, single word access
// - lower peripheral space to peripheral port
// - upper peripheral space to peripheral port
`timescale 1ns/10ps
module smmd_decoder (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire smmd_pkg::smmd_size_e size_i,
    input wire logic [smmd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [smmd_pkg::DATA_W-1:0] wdata_i,
    output logic ready_o,
    output logic ack_o,
    output logic unmapped_o,
    output logic [smmd_pkg::DATA_W-1:0] rdata_o,
    input wire logic remap_flash_i,
    output logic flash_rd_o,
    output logic [smmd_pkg::FLASH_HW_W-1:0] flash_addr_o,
    output logic flash_boot_o,
    input wire logic [smmd_pkg::HALF_W-1:0] flash_rdata_i,
    output logic periph_sel_o,
    output logic periph_hi_o,
    output logic periph_we_o,
    output logic [smmd_pkg::LANES-1:0] periph_be_o,
    output logic [smmd_pkg::ADDR_W-1:0] periph_addr_o,
    output logic [smmd_pkg::DATA_W-1:0] periph_wdata_o,
    input wire logic [smmd_pkg::DATA_W-1:0] periph_rdata_i,
    input wire logic periph_ready_i
);
    import smmd_pkg::*;

    typedef enum {ST_IDLE, ST_SRAM, ST_SRDATA, ST_FL1, ST_FL2, ST_FLEND, ST_PERIPH,
        ST_DONE} smmd_state_e;

    smmd_state_e state;
    smmd_tgt_e next_tgt;
    logic [ADDR_W-1:0] next_off;
    logic [LANES-1:0] next_be;
    logic [DATA_W-1:0] next_wdata;
    logic alias_flash;
    logic take;
    logic [ADDR_W-1:0] lat_off;
    logic [1:0] lat_lane;
    logic lat_we;
    smmd_size_e lat_size;
    logic [HALF_W-1:0] stage;

    smmd_sram_if sram ();

    smmd_sram u_sram (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .port(sram.mem)
    );

    // -------------------------------------------------------------------
    // little endian lane extraction of read data
    // -------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] pick(input logic [DATA_W-1:0] w,
        input logic [1:0] lane, input smmd_size_e sz);
        logic [DATA_W-1:0] r;
        r = w;
        case (sz)
            SZ_BYTE: r = {{(DATA_W-BYTE_W){1'b0}}, w[lane*BYTE_W +: BYTE_W]};
            SZ_HALF: r = {{(DATA_W-HALF_W){1'b0}}, w[lane[1]*HALF_W +: HALF_W]};
            default: r = w;
        endcase
        return r;
    endfunction : pick

    // -------------------------------------------------------------------
    // remap state: flash at zero from reset until the remap bit clears
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            alias_flash <= 1'b1;
        end
        else
        begin
            alias_flash <= remap_flash_i;
        end
    end

    // -------------------------------------------------------------------
    // address decode and byte lanes
    // -------------------------------------------------------------------
    always_comb
    begin
        next_tgt = TG_NONE;
        next_off = addr_i;
        if (addr_i < ALIAS_END)
        begin
            if (alias_flash)
            begin
                next_tgt = TG_FLASH;
            end
            else if (addr_i < SRAM_BYTES)
            begin
                next_tgt = TG_SRAM;
            end
        end
        else if (addr_i >= FLASH_BASE && addr_i < FLASH_END)
        begin
            next_tgt = TG_FLASH;
            next_off = addr_i - FLASH_BASE;
        end
        else if (addr_i >= SRAM_BASE && addr_i < SRAM_END)
        begin
            next_tgt = TG_SRAM;
            next_off = addr_i - SRAM_BASE;
        end
        else if ((addr_i >= PLO_BASE && addr_i < PLO_END) ||
            (addr_i >= PHI_BASE && addr_i < PHI_END))
        begin
            next_tgt = TG_PERIPH;
        end
    end

    always_comb
    begin
        case (size_i)
            SZ_BYTE:
            begin
                next_be = LANES'(4'h1 << addr_i[1:0]);
                next_wdata = {LANES{wdata_i[BYTE_W-1:0]}};
            end
            SZ_HALF:
            begin
                next_be = addr_i[1] ? 4'hC : 4'h3;
                next_wdata = {2{wdata_i[HALF_W-1:0]}};
            end
            default:
            begin
                next_be = 4'hF;
                next_wdata = wdata_i;
            end
        endcase
    end

    assign ready_o = (state == ST_IDLE);
    assign take = req_i && ready_o;

    // -------------------------------------------------------------------
    // access sequencer
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        case (next_tgt)
                            TG_SRAM: state <= ST_SRAM;
                            TG_FLASH: state <= we_i ? ST_DONE : ST_FL1;
                            TG_PERIPH: state <= ST_PERIPH;
                            default: state <= ST_DONE;
                        endcase
                    end
                end
                ST_SRAM: state <= ST_SRDATA;
                ST_SRDATA: state <= ST_IDLE;
                ST_FL1: state <= (lat_size == SZ_WORD) ? ST_FL2 : ST_FLEND;
                ST_FL2: state <= ST_FLEND;
                ST_FLEND: state <= ST_IDLE;
                ST_PERIPH: state <= periph_ready_i ? ST_IDLE : ST_PERIPH;
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // request capture
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lat_off <= '0;
            lat_lane <= '0;
            lat_we <= 1'b0;
            lat_size <= SZ_WORD;
            periph_hi_o <= 1'b0;
            periph_addr_o <= '0;
            periph_be_o <= '0;
            periph_wdata_o <= '0;
            flash_boot_o <= 1'b0;
        end
        else if (take)
        begin
            lat_off <= next_off;
            lat_lane <= addr_i[1:0];
            lat_we <= we_i;
            lat_size <= size_i;
            periph_hi_o <= (addr_i >= PHI_BASE);
            periph_addr_o <= addr_i;
            periph_be_o <= next_be;
            periph_wdata_o <= next_wdata;
            flash_boot_o <= (next_tgt == TG_FLASH) && (next_off >= FLASH_USER_BYTES);
        end
    end

    assign periph_we_o = lat_we;
    assign periph_sel_o = (state == ST_PERIPH);

    // -------------------------------------------------------------------
    // flash halfword port, one halfword per read
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flash_addr_o <= '0;
        end
        else if (take)
        begin
            flash_addr_o <= next_off[FLASH_OFF_W-1:1];
            if (size_i == SZ_WORD)
            begin
                flash_addr_o[0] <= 1'b0;
            end
        end
        else if (state == ST_FL1 && lat_size == SZ_WORD)
        begin
            flash_addr_o <= flash_addr_o + 1'b1;
        end
    end

    assign flash_rd_o = (state == ST_FL1) || (state == ST_FL2);

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stage <= '0;
        end
        else if (state == ST_FL2)
        begin
            stage <= flash_rdata_i;
        end
    end

    // -------------------------------------------------------------------
    // sram port
    // -------------------------------------------------------------------
    assign sram.en = (state == ST_SRAM);
    assign sram.we = lat_we;
    assign sram.be = periph_be_o;
    assign sram.addr = lat_off[SRAM_AW+WORD_LSB-1:WORD_LSB];
    assign sram.wdata = periph_wdata_o;

    // -------------------------------------------------------------------
    // answer to the core
    // -------------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            unmapped_o <= 1'b0;
            rdata_o <= '0;
        end
        else
        begin
            ack_o <= 1'b0;
            unmapped_o <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (take && next_tgt == TG_NONE)
                    begin
                        unmapped_o <= 1'b1;
                    end
                end
                ST_SRDATA:
                begin
                    ack_o <= 1'b1;
                    rdata_o <= lat_we ? '0 : pick(sram.rdata, lat_lane, lat_size);
                end
                ST_FLEND:
                begin
                    ack_o <= 1'b1;
                    rdata_o <= (lat_size == SZ_WORD) ? {flash_rdata_i, stage} :
                        pick({2{flash_rdata_i}}, lat_lane, lat_size);
                end
                ST_PERIPH:
                begin
                    if (periph_ready_i)
                    begin
                        ack_o <= 1'b1;
                        rdata_o <= lat_we ? '0 : pick(periph_rdata_i, lat_lane, lat_size);
                    end
                end
                ST_DONE:
                begin
                    ack_o <= 1'b1;
                    unmapped_o <= unmapped_o;
                    rdata_o <= '0;
                end
                default:
                begin
                    ack_o <= 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    one_target_a: assert property ($onehot0({sram.en, flash_rd_o, periph_sel_o}))
        else $error("more than one target selected");
    zero_flash_a: assert property (take && !we_i && addr_i < ALIAS_END && alias_flash
        |=> flash_rd_o &&
        flash_addr_o == ($past(addr_i[FLASH_OFF_W-1:1]) & ~15'($past(size_i) == SZ_WORD)))
        else $error("alias at zero did not reach flash");
    zero_sram_a: assert property (take && addr_i < SRAM_BYTES && !alias_flash
        |=> sram.en && sram.addr == $past(addr_i[SRAM_AW+1:2]))
        else $error("remapped zero did not reach sram");
    word_flash_two_a: assert property (take && !we_i && size_i == SZ_WORD && next_tgt == TG_FLASH
        |=> flash_rd_o ##1 flash_rd_o && flash_addr_o == $past(flash_addr_o) + 1'b1 ##2 ack_o)
        else $error("word flash read not two halfwords");
    sram_latency_a: assert property (sram.en |-> ##2 ack_o)
        else $error("sram access not answered in two cycles");
    lower_space_a: assert property (take && addr_i >= PLO_BASE && addr_i < PLO_END
        |=> periph_sel_o && !periph_hi_o && periph_addr_o == $past(addr_i))
        else $error("lower peripheral access misrouted");
    upper_space_a: assert property (take && addr_i >= PHI_BASE && addr_i < PHI_END
        |=> periph_sel_o && periph_hi_o)
        else $error("upper peripheral access misrouted");
    byte_lane_a: assert property (sram.en && lat_size == SZ_BYTE
        |-> sram.be == 4'(4'h1 << lat_lane))
        else $error("byte lane wrong");
    unmapped_quiet_a: assert property (take && next_tgt == TG_NONE
        |=> unmapped_o && !sram.en && !periph_sel_o ##1 ack_o && rdata_o == '0)
        else $error("unmapped access not harmless");

    sram_word_c: cover property (sram.en && !sram.we && lat_size == SZ_WORD ##2 ack_o);
    flash_word_c: cover property (state == ST_FL2 ##2 ack_o);
    periph_wait_c: cover property (periph_sel_o && !periph_ready_i ##1 periph_sel_o);
    unmapped_c: cover property (unmapped_o);
endmodule : smmd_decoder

// ### pkg/smmd_pkg.sv
// Purpose: shared constants and types of the system memory map decoder
// Assumes: 32-bit byte address, 32-bit data
// Notes: region bases of flash and sram are placement choices of this build
package smmd_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;
    localparam int LANES = 4;
    localparam int WORD_LSB = 2;
    // -------------------------------------------------------------------
    // flash: 32k halfwords, 256 byte program pages, top 2k boot page
    // -------------------------------------------------------------------
    localparam int FLASH_HW_W = 15;
    localparam int FLASH_OFF_W = 16;
    localparam logic [31:0] FLASH_PAGE_BYTES = 32'h0000_0100;
    localparam logic [31:0] FLASH_USER_BYTES = 32'h0000_F800;
    localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
    localparam logic [31:0] FLASH_END = 32'h0009_0000;
    // -------------------------------------------------------------------
    // sram: 2k words of 32 bits
    // -------------------------------------------------------------------
    localparam int SRAM_AW = 11;
    localparam int SRAM_WORDS = 2048;
    localparam logic [31:0] SRAM_BYTES = 32'h0000_2000;
    localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
    localparam logic [31:0] SRAM_END = 32'h0001_2000;
    // -------------------------------------------------------------------
    // alias window at zero and peripheral register space
    // -------------------------------------------------------------------
    localparam logic [31:0] ALIAS_END = 32'h0001_0000;
    localparam logic [31:0] PLO_BASE = 32'hFFFF_0000;
    localparam logic [31:0] PLO_END = 32'hFFFF_0B54;
    localparam logic [31:0] PHI_BASE = 32'hFFFF_F400;
    localparam logic [31:0] PHI_END = 32'hFFFF_FC3C;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_RSVD} smmd_size_e;
    typedef enum logic [1:0] {TG_SRAM, TG_FLASH, TG_PERIPH, TG_NONE} smmd_tgt_e;
endpackage : smmd_pkg

// ### pkg/smmd_sram_if.sv
// Purpose: port bundle between the decoder and its sram array
// Assumes: read data one clock after an enabled read
// Notes: none
`timescale 1ns/10ps
interface smmd_sram_if;
    import smmd_pkg::*;
    logic en;
    logic we;
    logic [LANES-1:0] be;
    logic [SRAM_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport master (output en, we, be, addr, wdata, input rdata);
    modport mem (input en, we, be, addr, wdata, output rdata);
endinterface : smmd_sram_if

// ### hw/smmd_sram.sv
// Purpose: 2k x 32 sram array with byte lanes and registered read data
// Assumes: one access per enabled cycle
// Notes: array contents are not reset
`timescale 1ns/10ps
module smmd_sram (
    input wire logic clock_i,
    input wire logic rst_i,
    smmd_sram_if.mem port
);
    import smmd_pkg::*;
    logic [DATA_W-1:0] mem [SRAM_WORDS];

    always_ff @(posedge clock_i)
    begin
        if (port.en && port.we)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (port.be[i])
                begin
                    mem[port.addr][i*BYTE_W +: BYTE_W] <= port.wdata[i*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            port.rdata <= '0;
        end
        else if (port.en && !port.we)
        begin
            port.rdata <= mem[port.addr];
        end
    end
endmodule : smmd_sram

// ### test/smmd_far_model.sv
// Purpose: flash array and peripheral responder facing the decoder
// Assumes: flash data one cycle after each read strobe
// Notes: released data lines toggle so a stale value never matches
`timescale 1ns/10ps
module smmd_far_model (
    input wire logic clock_i,
    input wire logic flash_rd_i,
    input wire logic [smmd_pkg::FLASH_HW_W-1:0] flash_addr_i,
    output logic [smmd_pkg::HALF_W-1:0] flash_rdata_o,
    input wire logic sel_i,
    input wire logic we_i,
    input wire logic [smmd_pkg::LANES-1:0] be_i,
    input wire logic [smmd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [smmd_pkg::DATA_W-1:0] wdata_i,
    input wire logic [3:0] wait_i,
    output logic [smmd_pkg::DATA_W-1:0] rdata_o,
    output logic ready_o,
    output logic [smmd_pkg::LANES-1:0] last_be_o,
    output logic [smmd_pkg::DATA_W-1:0] last_wdata_o
);
    import smmd_pkg::*;
    logic [3:0] cnt;
    logic [DATA_W-1:0] word;
    // ---------------------------------------------------------------
    // flash: one halfword per strobe, answered next cycle
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (flash_rd_i)
            flash_rdata_o <= 16'h1234 + {flash_addr_i, 1'b1};
        else
            flash_rdata_o <= ~flash_rdata_o;
    end
    // ---------------------------------------------------------------
    // peripheral: answers after wait_i stalled cycles
    // ---------------------------------------------------------------
    assign word = {addr_i[31:2], 2'b00} ^ 32'h5A5A_0000;
    assign ready_o = sel_i && (cnt == wait_i);
    assign rdata_o = ready_o ? word : ~word;
    always_ff @(posedge clock_i)
    begin
        if (!sel_i || ready_o)
            cnt <= 4'h0;
        else
            cnt <= cnt + 4'h1;
    end
    always_ff @(posedge clock_i)
    begin
        if (ready_o && we_i)
        begin
            last_be_o <= be_i;
            last_wdata_o <= wdata_i;
        end
    end
endmodule : smmd_far_model

// ### test/tb_system_memory_map_decoder.sv
// Purpose: self-checking bench of the memory map decoder
// Assumes: stimulus on falling edges, results read on falling edges
// Notes: the bench touches reserved peripheral holes at PLO_END and PHI_END, expecting unmapped
`timescale 1ns/10ps
module tb_system_memory_map_decoder;
    import smmd_pkg::*;
    logic clock_i, rst_i, req, we, remap, ack_o, ready_o, unmapped_o, flash_rd_o, flash_boot_o;
    logic periph_sel_o, periph_hi_o, periph_we_o, periph_ready_i;
    smmd_size_e size;
    logic [31:0] addr, wdata, rdata_o, periph_addr_o, periph_wdata_o, periph_rdata_i, rd;
    logic [31:0] last_wdata;
    logic [3:0] periph_be_o, last_be, wait_n;
    logic [14:0] flash_addr_o;
    logic [15:0] flash_rdata_i;
    logic unm, boot, hi;
    int lat, nrd, fails, comparisons;

    smmd_decoder dut (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .we_i(we), .size_i(size),
        .addr_i(addr), .wdata_i(wdata), .ready_o(ready_o), .ack_o(ack_o),
        .unmapped_o(unmapped_o), .rdata_o(rdata_o), .remap_flash_i(remap),
        .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o), .flash_boot_o(flash_boot_o),
        .flash_rdata_i(flash_rdata_i), .periph_sel_o(periph_sel_o), .periph_hi_o(periph_hi_o),
        .periph_we_o(periph_we_o), .periph_be_o(periph_be_o), .periph_addr_o(periph_addr_o),
        .periph_wdata_o(periph_wdata_o), .periph_rdata_i(periph_rdata_i),
        .periph_ready_i(periph_ready_i));
    smmd_far_model far (.clock_i(clock_i), .flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o),
        .flash_rdata_o(flash_rdata_i), .sel_i(periph_sel_o), .we_i(periph_we_o),
        .be_i(periph_be_o), .addr_i(periph_addr_o), .wdata_i(periph_wdata_o), .wait_i(wait_n),
        .rdata_o(periph_rdata_i), .ready_o(periph_ready_i), .last_be_o(last_be),
        .last_wdata_o(last_wdata));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] fx(input logic [14:0] i);
        return 16'h1234 + {i, 1'b1};
    endfunction : fx
    function automatic logic [31:0] pw(input logic [31:0] a);
        return {a[31:2], 2'b00} ^ 32'h5A5A_0000;
    endfunction : pw
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (4) @(negedge clock_i);
        rst_i = 1'b0;
    endtask : do_reset
    // one core bus transfer; records latency, strobes and side flags
    task automatic acc(input logic w, input smmd_size_e sz, input logic [31:0] a,
                       input logic [31:0] d, input logic [31:0] exp, input int el,
                       input string what);
        @(negedge clock_i);
        req = 1'b1;
        we = w;
        size = sz;
        addr = a;
        wdata = d;
        @(negedge clock_i);
        req = 1'b0;
        chk(32'(ready_o), 32'd0, "busy");
        lat = 1;
        nrd = 0;
        unm = 1'b0;
        boot = 1'b0;
        hi = 1'b0;
        while (ack_o !== 1'b1 && lat < 40)
        begin
            if (flash_rd_o === 1'b1)
            begin
                nrd++;
                boot = boot | flash_boot_o;
            end
            if (periph_sel_o === 1'b1)
                hi = periph_hi_o;
            unm = unm | (unmapped_o === 1'b1);
            @(negedge clock_i);
            lat++;
        end
        if (lat >= 40)
        begin
            fails++;
            $display("BAD %0t no answer %s", $time, what);
            end_sim();
        end
        rd = rdata_o;
        chk(32'(ready_o), 32'd1, "ready again");
        chk(rd, exp, what);
        chk(32'(lat), 32'(el), "latency");
    endtask : acc
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_flash();
        acc(1'b0, SZ_WORD, 32'h0, 32'h0, {fx(15'h1), fx(15'h0)}, 4, "alias flash");
        chk(32'(nrd), 32'd2, "two reads");
        acc(1'b0, SZ_WORD, FLASH_BASE + 32'h4, 32'h0, {fx(15'h3), fx(15'h2)}, 4, "fl word");
        acc(1'b0, SZ_BYTE, FLASH_BASE + 32'h3, 32'h0, {24'h0, 8'(fx(15'h1) >> 8)}, 3, "fl byte");
        chk(32'(nrd), 32'd1, "one read");
        acc(1'b0, SZ_HALF, FLASH_BASE + 32'hF7FE, 32'h0, {16'h0, fx(15'h7BFF)}, 3, "user");
        chk(32'(boot), 32'd0, "user page");
        acc(1'b0, SZ_HALF, FLASH_BASE + 32'hF802, 32'h0, {16'h0, fx(15'h7C01)}, 3, "boot");
        chk(32'(boot), 32'd1, "boot page");
        acc(1'b0, SZ_HALF, FLASH_END - 32'h2, 32'h0, {16'h0, fx(15'h7FFF)}, 3, "last hw");
        acc(1'b0, SZ_WORD, FLASH_END, 32'h0, 32'h0, 2, "past flash");
        chk(32'(unm), 32'd1, "flash end");
        acc(1'b1, SZ_WORD, FLASH_BASE, 32'hFFFF_FFFF, 32'h0, 2, "flash write");
    endtask : t_flash
    task automatic t_sram();
        acc(1'b1, SZ_WORD, SRAM_BASE + 32'h4, 32'h4433_2211, 32'h0, 3, "wr word");
        acc(1'b1, SZ_BYTE, SRAM_BASE + 32'h5, 32'h0000_00AB, 32'h0, 3, "wr byte");
        acc(1'b1, SZ_HALF, SRAM_BASE + 32'h6, 32'h0000_CDEF, 32'h0, 3, "wr half");
        acc(1'b0, SZ_WORD, SRAM_BASE + 32'h4, 32'h0, 32'hCDEF_AB11, 3, "rd word");
        acc(1'b0, SZ_BYTE, SRAM_BASE + 32'h7, 32'h0, 32'h0000_00CD, 3, "rd byte");
        acc(1'b0, SZ_HALF, SRAM_BASE + 32'h4, 32'h0, 32'h0000_AB11, 3, "rd half");
        acc(1'b1, SZ_WORD, SRAM_END - 32'h4, 32'h8765_4321, 32'h0, 3, "top wr");
        acc(1'b0, SZ_WORD, SRAM_END - 32'h4, 32'h0, 32'h8765_4321, 3, "top rd");
        acc(1'b1, SZ_WORD, 32'h0002_0000, 32'h0, 32'h0, 2, "hole write");
        chk(32'(unm), 32'd1, "hole flag");
        acc(1'b0, SZ_WORD, SRAM_BASE + 32'h4, 32'h0, 32'hCDEF_AB11, 3, "untouched");
    endtask : t_sram
    task automatic t_remap();
        @(negedge clock_i);
        remap = 1'b0;
        repeat (2) @(negedge clock_i);
        acc(1'b0, SZ_WORD, 32'h4, 32'h0, 32'hCDEF_AB11, 3, "alias sram");
        acc(1'b0, SZ_WORD, SRAM_BYTES, 32'h0, 32'h0, 2, "alias end");
        chk(32'(unm), 32'd1, "alias end flag");
        remap = 1'b1;
        do_reset();
        acc(1'b0, SZ_WORD, 32'h0, 32'h0, {fx(15'h1), fx(15'h0)}, 4, "after reset");
    endtask : t_remap
    task automatic t_periph();
        for (int w = 0; w < 4; w += 3)
        begin
            wait_n = 4'(w);
            acc(1'b0, SZ_WORD, PLO_BASE + 32'h220, 32'h0, pw(PLO_BASE + 32'h220), 2 + w, "lo");
            chk(32'(hi), 32'd0, "lo space");
            acc(1'b0, SZ_WORD, PHI_END - 32'h4, 32'h0, pw(PHI_END - 32'h4), 2 + w, "hi");
            chk(32'(hi), 32'd1, "hi space");
        end
        wait_n = 4'h1;
        acc(1'b0, SZ_WORD, PLO_END - 32'h4, 32'h0, pw(PLO_END - 32'h4), 3, "lo top");
        acc(1'b0, SZ_WORD, PHI_BASE, 32'h0, pw(PHI_BASE), 3, "hi base");
        acc(1'b0, SZ_BYTE, PLO_BASE + 32'h223, 32'h0, pw(PLO_BASE) >> 24, 3, "p byte");
        acc(1'b1, SZ_BYTE, PLO_BASE + 32'h221, 32'h0000_00AB, 32'h0, 3, "p write");
        chk(32'(last_be), 32'h2, "lane enable");
        chk(32'(last_wdata[15:8]), 32'hAB, "lane data");
        acc(1'b0, SZ_WORD, PLO_END, 32'h0, 32'h0, 2, "lo end");
        chk(32'(unm), 32'd1, "lo end flag");
        acc(1'b0, SZ_WORD, PHI_END, 32'h0, 32'h0, 2, "hi end");
        acc(1'b0, SZ_WORD, PLO_BASE - 32'h4, 32'h0, 32'h0, 2, "below lo");
    endtask : t_periph
    // ---------------------------------------------------------------
    // main sequence; reserved peripheral holes are addressed and must answer as unmapped
    // ---------------------------------------------------------------
    initial
    begin
        fails = 0;
        comparisons = 0;
        req = 1'b0;
        we = 1'b0;
        size = SZ_WORD;
        addr = 32'h0;
        wdata = 32'h0;
        remap = 1'b1;
        wait_n = 4'h0;
        do_reset();
        t_flash();
        t_sram();
        t_remap();
        t_periph();
        end_sim();
    end
endmodule : tb_system_memory_map_decoder
